// file: sram_host_ctrl.sv
// Purpose: Host that reads and writes a 1K x 4 asynchronous static memory
// Assumes: Memory pins wired directly; read data resynchronised here
// Notes:   One request at a time; whole-cycle timing from a 100 ns clock
//          Reads pay two extra cycles for the input synchroniser
//          Write data is let go on the same edge the strobe rises
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl
  import sram_host_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
)(
  input  wire logic          sys_clk_i,
  input  wire logic          srst_i,
  // User request side
  input  wire logic          req_valid_i,
  input  wire logic          req_write_i,
  input  wire logic [AW-1:0] req_addr_i,
  input  wire logic [DW-1:0] req_wdata_i,
  output logic               req_ready_o,
  output logic               rd_valid_o,
  output logic [DW-1:0]      rd_data_o,
  // Memory pins
  output logic [AW-1:0]      mem_addr_o,
  output logic               mem_select_n_o,
  output logic               mem_write_n_o,
  input  wire logic [DW-1:0] mem_data_i,
  output logic [DW-1:0]      mem_data_o,
  output logic               mem_data_oe_o
);
  // One-hot phases of a memory cycle
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_SETUP   = 6'h02,
    ST_WRITE   = 6'h04,
    ST_RECOVER = 6'h08,
    ST_READ    = 6'h10,
    ST_FLOAT   = 6'h20
  } state_e;

  // Phase state, timer handshake, captured request and input flops
  state_e           state_reg;
  state_e           state_next;
  logic             tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic             tmr_done;
  logic             wr_reg;
  logic [DW-1:0]    din_meta_reg;
  logic [DW-1:0]    din_sync_reg;

  // A request is taken only from idle; offers made while busy are lost
  function automatic logic takes_request(input state_e s, input logic v);
    return (s == ST_IDLE) && v;
  endfunction

  // Select spans both data phases, never setup, recovery or float
  function automatic logic in_select_phase(input state_e s);
    return (s == ST_WRITE) || (s == ST_READ);
  endfunction

  // Strobe and data drive share one phase so they rise and fall together
  function automatic logic in_write_phase(input state_e s);
    return (s == ST_WRITE);
  endfunction

  // A phase counts down to zero, so the load is one short of its length
  function automatic logic [CNT_W-1:0] phase_load(input int cycles);
    return CNT_W'(cycles - 1);
  endfunction

  sram_host_timer i_sram_host_timer (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .load_i    (tmr_load),
    .value_i   (tmr_value),
    .done_o    (tmr_done)
  );

  // Two flops on the data pins; the memory is asynchronous to us
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      din_meta_reg <= '0;
      din_sync_reg <= '0;
    end else begin
      din_meta_reg <= mem_data_i;
      // Only this stage is read; the first may still be settling
      din_sync_reg <= din_meta_reg;
    end
  end

  // Phase sequencing; address set up before select, held after strobe
  always_comb begin
    state_next = state_reg;
    tmr_load   = 1'b0;
    tmr_value  = '0;
    case (state_reg)
      ST_IDLE: begin
        // Setup cycle lets the address settle before select falls
        if (takes_request(state_reg, req_valid_i)) begin
          state_next = ST_SETUP;
          tmr_load   = 1'b1;
          tmr_value  = phase_load(SETUP_CYC);
        end
      end
      ST_SETUP: begin
        if (tmr_done) begin
          state_next = wr_reg ? ST_WRITE : ST_READ;
          tmr_load   = 1'b1;
          // Read waits access plus two sync stages
          tmr_value  = wr_reg ? CNT_W'(WRITE_CYC) :
                                CNT_W'(ACCESS_CYC + SYNC_STAGES);
        end
      end
      ST_WRITE: begin
        // Strobe and select rise here; address stays through recovery
        if (tmr_done) begin
          state_next = ST_RECOVER;
          tmr_load   = 1'b1;
          tmr_value  = phase_load(RECOVER_CYC);
        end
      end
      ST_RECOVER: begin
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_READ: begin
        // Select rises here; the memory gets a cycle to float
        if (tmr_done) begin
          state_next = ST_FLOAT;
          tmr_load   = 1'b1;
          tmr_value  = phase_load(FLOAT_CYC);
        end
      end
      ST_FLOAT: begin
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        // Any illegal code falls back to idle
        state_next = ST_IDLE;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Capture request on acceptance; address stays put until idle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wr_reg     <= 1'b0;
      mem_addr_o <= '0;
      mem_data_o <= '0;
    end else if (takes_request(state_reg, req_valid_i)) begin
      wr_reg     <= req_write_i;
      mem_addr_o <= req_addr_i;
      // Write data waits on the pins; only the enable puts it out
      mem_data_o <= req_wdata_i;
    end
  end

  // Registered pins keep glitches off the asynchronous strobes
  // Select and strobe fall together, so outputs stay off
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mem_select_n_o <= 1'b1;
      mem_write_n_o  <= 1'b1;
      mem_data_oe_o  <= 1'b0;
    end else begin
      mem_select_n_o <= !in_select_phase(state_next);
      mem_write_n_o  <= !in_write_phase(state_next);
      // Drive only in the overlap; released with the strobe rise
      mem_data_oe_o  <= in_write_phase(state_next);
    end
  end

  // Read data taken at the end of the access window
  // Pulse for one cycle; data holds until the next read
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
    end else begin
      rd_valid_o <= 1'b0;
      if (state_reg == ST_READ && tmr_done) begin
        rd_valid_o <= 1'b1;
        rd_data_o  <= din_sync_reg;
      end
    end
  end

  // Ready straight from the phase register, no added latency
  assign req_ready_o = (state_reg == ST_IDLE);
endmodule
`default_nettype wire

// file: sram_host_pkg.sv
// Purpose: Constants for the 1K x 4 static memory host controller
// Assumes: 10 MHz system clock, 100 ns period
// Notes:   Times in ns, cycle counts derived from the clock period
package sram_host_pkg;
  localparam int CLK_PERIOD_NS     = 100;
  localparam int ADDR_W            = 10;
  localparam int DATA_W            = 4;
  // Least times the host must honour, in ns
  localparam int ADDR_SETUP_NS     = 15;
  localparam int SELECT_WRITE_NS   = 50;   // overlap, select falls late
  localparam int ADDR_TO_END_NS    = 65;   // overlap otherwise, and address
  localparam int WRITE_RECOVERY_NS = 5;    // write_recovery_interval
  localparam int DATA_HOLD_NS      = 5;
  // Longest times the memory takes, in ns
  localparam int READ_ACCESS_NS    = 70;
  localparam int DESELECT_FLOAT_NS = 40;   // deselect_float_interval
  localparam int WRITE_FLOAT_NS    = 35;

  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SETUP_CYC   = ns_to_cycles(ADDR_SETUP_NS);
  localparam int WRITE_CYC   = ns_to_cycles(ADDR_TO_END_NS);
  localparam int RECOVER_CYC = ns_to_cycles(WRITE_RECOVERY_NS);
  localparam int ACCESS_CYC  = ns_to_cycles(READ_ACCESS_NS);
  localparam int FLOAT_CYC   = ns_to_cycles(DESELECT_FLOAT_NS);
  localparam int SYNC_STAGES = 2;   // Flops on the data inputs
  localparam int CNT_W       = 4;
endpackage

// file: sram_host_timer.sv
// Purpose: Down counter timing each phase of a memory cycle
// Assumes: Load and count on sys_clk_i, synchronous reset
// Notes:   done_o is high while the count is zero
`timescale 1ns/1ps
`default_nettype none
module sram_host_timer
  import sram_host_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] value_i,
  output logic                  done_o
);
  logic [CNT_W-1:0] count_reg;

  // Load wins over counting so each phase starts afresh
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      count_reg <= '0;
    end else if (load_i) begin
      count_reg <= value_i;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign done_o = (count_reg == '0);
endmodule
`default_nettype wire

// file: sram_host_sva.sv
// Purpose: Pin timing checks for the memory host
// Assumes: One 100 ns clock, synchronous reset
// Notes:   Watches memory pins only
`timescale 1ns/1ps
`default_nettype none
module sram_host_sva #(parameter int AW = 10) (
  input wire logic          sys_clk_i,
  input wire logic          srst_i,
  input wire logic [AW-1:0] mem_addr_o,
  input wire logic          mem_select_n_o,
  input wire logic          mem_write_n_o,
  input wire logic          mem_data_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Strobe low two cycles, then raised
  sequence wr_pulse;
    !mem_write_n_o [*2] ##1 mem_write_n_o;
  endsequence
  AST_WR_WIDTH: assert property ($fell(mem_write_n_o) |-> wr_pulse)
    else $error("write strobe width wrong");
  AST_SEL_TOGETHER: assert property ($fell(mem_write_n_o) |-> $fell(mem_select_n_o))
    else $error("select did not fall with strobe");
  AST_ADDR_IN_WRITE: assert property (!mem_write_n_o |-> $stable(mem_addr_o) && !mem_select_n_o)
    else $error("address moved during write");
  AST_ADDR_HOLD: assert property ($rose(mem_write_n_o) |=> $stable(mem_addr_o))
    else $error("address not held after write");
  AST_RELEASE: assert property ($rose(mem_write_n_o) |-> !mem_data_oe_o)
    else $error("data still driven after write");
  AST_NO_FIGHT: assert property (mem_data_oe_o |-> !mem_write_n_o && !mem_select_n_o)
    else $error("data driven outside write");
endmodule
`default_nettype wire

// file: sram_mem_model.sv
// Purpose: Behavioural 1K x 4 static memory
// Assumes: Pins driven by a clocked host
// Notes:   Floating pins show inverted stored data
`timescale 1ns/1ps
`default_nettype none
module sram_mem_model #(parameter int ACC_NS = 70) (
  input  wire logic [9:0] addr_i,
  input  wire logic       select_n_i,
  input  wire logic       write_n_i,
  input  wire logic [3:0] host_d_i,
  input  wire logic       host_oe_i,
  output logic      [3:0] pin_o
);
  logic [3:0] cells [1024];
  logic       rd_ok;
  logic [9:0] addr_d;
  wire        overlap = !select_n_i && !write_n_i;
  wire        standby = select_n_i;
  initial for (int i = 0; i < 1024; i++) cells[i] = 4'h0;
  // Slowest legal answer, so early sampling shows up
  assign #(ACC_NS) rd_ok = !select_n_i && write_n_i;
  assign #(ACC_NS) addr_d = addr_i;
  // Release at once; never drive during a write
  assign pin_o = host_oe_i ? host_d_i :
    (rd_ok && !standby && write_n_i) ? cells[addr_d] :
    ~cells[addr_d];
  // Store at the end of the overlap
  always @(negedge overlap) cells[addr_i] = host_d_i;
endmodule
`default_nettype wire

// file: sram_host_ctrl_bench.sv
// Purpose: Self-checking bench for the memory host
// Assumes: Memory model behind the pins
// Notes:   Stray requests while busy must be ignored
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl_bench;
  import sram_host_pkg::*;
  logic          sys_clk_i, srst_i, req_valid_i, req_write_i;
  logic [10-1:0] req_addr_i, mem_addr_o;
  logic [4-1:0]  req_wdata_i, rd_data_o, mem_data_i, mem_data_o;
  logic          req_ready_o, rd_valid_o, mem_data_oe_o;
  logic          mem_select_n_o, mem_write_n_o;
  wire logic [3:0] pin_state = {mem_select_n_o, mem_write_n_o, mem_data_oe_o,
    req_ready_o};
  logic [3:0]    shadow [1024];
  logic [3:0]    exp_q [$];
  int            failures, checked, seed;
  sram_host_ctrl i_sram_host_ctrl (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .mem_addr_o(mem_addr_o),
    .mem_select_n_o(mem_select_n_o), .mem_write_n_o(mem_write_n_o),
    .mem_data_i(mem_data_i), .mem_data_o(mem_data_o),
    .mem_data_oe_o(mem_data_oe_o));
  sram_mem_model i_sram_mem_model (.addr_i(mem_addr_o),
    .select_n_i(mem_select_n_o), .write_n_i(mem_write_n_o),
    .host_d_i(mem_data_o), .host_oe_i(mem_data_oe_o), .pin_o(mem_data_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One request, then a stray write offered while busy
  task automatic op(input logic w, input logic [9:0] a, input logic [3:0] d);
    @(posedge sys_clk_i);
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i} <= {1'b1, w, a, d};
    @(posedge sys_clk_i);
    while (req_ready_o !== 1'b1) @(posedge sys_clk_i);
    if (w) shadow[a] = d;
    else exp_q.push_back(shadow[a]);
    req_write_i <= 1'b1;
    req_wdata_i <= ~d;
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    for (int n = 0; n < 30 && req_ready_o !== 1'b1; n++) @(posedge sys_clk_i);
    check({3'h0, req_ready_o}, 4'h1);
  endtask
  // Each read result against the oldest note
  always @(posedge sys_clk_i)
    if (rd_valid_o === 1'b1) check(rd_data_o, exp_q.pop_front());
  initial begin
    srst_i = 1'b1;
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = 16'h0;
    {failures, checked, seed} = {32'h0, 32'h0, 32'd48346};
    foreach (shadow[i]) shadow[i] = 4'h0;
    repeat (5) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    // Pins idle and ready up straight out of reset
    check(pin_state, 4'hd);
    // Boundary words back to back, then a random mix
    op(1, 10'h000, 4'ha); op(1, 10'h3ff, 4'h5);
    op(0, 10'h3ff, 4'h0); op(0, 10'h000, 4'h0);
    repeat (40) op(1'($random(seed)), 10'($random(seed) & 32'h307),
      4'($random(seed)));
    // Reset in mid-read: pins go idle at once and no result follows
    @(posedge sys_clk_i);
    {req_valid_i, req_write_i, req_addr_i} <= {1'b1, 1'b0, 10'h000};
    repeat (4) @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    srst_i      <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    check(pin_state, 4'hd);
    op(0, 10'h3ff, 4'h0);
    repeat (20) @(posedge sys_clk_i);
    check(4'(exp_q.size()), 4'h0);
    conclude();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    failures++;
    conclude();
  end
endmodule
bind sram_host_ctrl sram_host_sva #(.AW(AW)) i_sram_host_sva (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .mem_addr_o(mem_addr_o),
  .mem_select_n_o(mem_select_n_o), .mem_write_n_o(mem_write_n_o),
  .mem_data_oe_o(mem_data_oe_o));
`default_nettype wire
